// file: pkg/ccpt_map.vh
`ifndef CCPT_MAP_VH
`define CCPT_MAP_VH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define CCPT_IDX_DIR 8'h00
`define CCPT_IDX_FORCE 8'h01
`define CCPT_IDX_MASK7 8'h02
`define CCPT_IDX_DATA7 8'h03
`define CCPT_IDX_COUNT 8'h04
`define CCPT_IDX_CTRL1 8'h06
`define CCPT_IDX_MODE 8'h08
`define CCPT_IDX_EDGE 8'h0a
`define CCPT_IDX_IEN 8'h0c
`define CCPT_IDX_CTRL2 8'h0d
`define CCPT_IDX_FLAG1 8'h0e
`define CCPT_IDX_FLAG2 8'h0f
`define CCPT_IDX_VAL0 8'h10
`define CCPT_IDX_ACTL 8'h20
`define CCPT_IDX_AFLG 8'h21
`define CCPT_IDX_ACNTH 8'h22
`define CCPT_IDX_ACNTL 8'h23
`define CCPT_IDX_PORT 8'h30
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCPT_C1_TEN 7
`define CCPT_C1_FFCA 4
`define CCPT_C2_TOI 7
`define CCPT_C2_CRE 3
`define CCPT_AC_EN 6
`define CCPT_AC_MOD 5
`define CCPT_AC_EDGE 4
`define CCPT_AC_CLKH 3
`define CCPT_AC_CLKL 2
`define CCPT_AC_OVI 1
`define CCPT_AC_INI 0
`define CCPT_AF_OVF 1
`define CCPT_AF_INF 0
`define CCPT_F2_TOF 7
// ----------------------------------------
// Constants and reset values
// ----------------------------------------
`define CCPT_RST8 8'h00
`define CCPT_RST16 16'h0000
`define CCPT_CNT_MAX 16'hffff
`define CCPT_DIV64_MASK 6'h3f
`define CCPT_LOW_MAX 8'hff
`endif

// file: rtl/ccpt_timer.v
// Summary of operation
// RQ1 - Fast clear: count access clears accumulator flags
// RQ2 - Overflow flag set on count rollover
// RQ3 - Accumulator flags cleared by one, timer enabled
// RQ4 - Input flag on counting or trailing gate edge
// RQ5 - Software accesses pulse count as one word
// RQ6 - Accumulator pin synchronised before counting
// RQ7 - Prescaler divides by one to 128
// RQ8 - Capture copies counter, sets channel flag
// RQ9 - Channel flag interrupts when enabled; W1C
// RQ10 - Compare sets flag, drives pin by mode
// RQ11 - Force bit does compare action, no flag
// RQ12 - Channel 7 overrides; mask gates its data
// RQ13 - Channel 7 compare resets counter when enabled; no reset when the channel 7 value is zero
// RQ14 - Counter holds top value one cycle
// RQ15 - Port writes latched while compare owns pin
// RQ16 - Event mode counts selected pin edges
// RQ17 - Overflow interrupt only when enabled
// RQ18 - Event counting runs with timer disabled
// RQ19 - Gated mode counts divide-by-64 while active
// RQ20 - No gated counting while timer disabled
// RQ21 - Eleven active-high interrupt request outputs
// RQ22 - Accumulator disabled: counter uses prescaler
// RQ23 - Clock select picks counter clock immediately
// RQ24 - Two-stage synchroniser, short pulses missed
`timescale 1ns/1ps
`default_nettype none
`include "ccpt_map.vh"
module ccpt_timer
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Channel pins
  input wire [7:0] chanPinIn,
  output reg [7:0] chanPinOut,
  output reg [7:0] chanPinOe,
  // Interrupt requests
  output reg [7:0] chanIrq,
  output reg accumInputIrq,
  output reg accumOverflowIrq,
  output reg counterOverflowIrq
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [6:0] presMask;
    input [2:0] sel;
    begin
      presMask = (7'h01 << sel) - 7'h01;
    end
  endfunction

  // Mode/level: 00 off, 01 toggle, 10 clear, 11 set
  function ocAct;
    input [1:0] ml;
    input cur;
    begin
      case (ml)
        2'b01: ocAct = ~cur;
        2'b10: ocAct = 1'b0;
        2'b11: ocAct = 1'b1;
        default: ocAct = cur;
      endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] channelDirection;
  reg [7:0] channel7Mask;
  reg [7:0] channel7Data;
  reg [15:0] modeLevel;
  reg [15:0] capEdgeCfg;
  reg [7:0] channelIrqEnable;
  reg [7:0] portLatch;
  reg timerEnable;
  reg fastFlagClear;
  reg counterOverflowIrqEnable;
  reg counterResetEnable;
  reg [2:0] prescaleSelect;
  reg [7:0] accumCtrl;
  reg [7:0] channelFlag;
  reg counterOverflowFlag;
  reg accumOverflowFlag;
  reg accumInputFlag;
  reg [15:0] freeRunningCounter;
  reg cntUpd;
  reg [15:0] pulseCount;
  reg [6:0] presCnt;
  reg [15:0] channelValue [0:7];
  reg [7:0] ocState;
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] sync3;
  reg wrPend;
  reg [7:0] wrIdx;
  reg [31:0] rdMux;
  integer k;
  integer j;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire busTake = hsel & hready & htrans[1];
  wire [7:0] aIdx = haddr[9:2];
  wire wrStrobe = wrPend;
  wire acntAccess = busTake &
    ((aIdx == `CCPT_IDX_ACNTH) | (aIdx == `CCPT_IDX_ACNTL));
  wire [7:0] wrForce = (wrStrobe && wrIdx == `CCPT_IDX_FORCE) ?
    (hwdata[7:0] & channelDirection) : `CCPT_RST8;

  // ----------------------------------------
  // Pin edges
  // ----------------------------------------
  wire [7:0] rise = sync2 & ~sync3;
  wire [7:0] fall = ~sync2 & sync3;

  // ----------------------------------------
  // Prescaler and accumulator clocking
  // ----------------------------------------
  wire accumEnable = accumCtrl[`CCPT_AC_EN];
  wire accumGated = accumCtrl[`CCPT_AC_MOD];
  wire accumEdge = accumCtrl[`CCPT_AC_EDGE];
  wire [1:0] clkSel = accumCtrl[`CCPT_AC_CLKH:`CCPT_AC_CLKL];
  // RQ7 - prescale divide
  wire presTick = timerEnable &
    ((presCnt & presMask(prescaleSelect)) == presMask(prescaleSelect));
  // RQ20 - no div64 when off
  wire div64Tick = timerEnable & (presCnt[5:0] == `CCPT_DIV64_MASK);
  // Event edge and gate trailing edge coincide for each edge setting
  wire accEdge = accumEdge ? rise[7] : fall[7];
  wire gateOn = accumEdge ? ~sync2[7] : sync2[7];
  // RQ16 - event edge count
  // RQ18 - no timer gating
  // RQ19 - gated div64 count
  wire accumInc = accumEnable &
    (accumGated ? (div64Tick & gateOn) : accEdge);

  // ----------------------------------------
  // Counter clock and compare
  // ----------------------------------------
  reg cntTick;
  // RQ22 - prescaler when disabled
  // RQ23 - clock select
  always @*
  begin
    if (!accumEnable || clkSel == 2'b00)
      cntTick = presTick;
    else if (clkSel == 2'b01)
      cntTick = timerEnable & accumInc;
    else if (clkSel == 2'b10)
      cntTick = timerEnable & accumInc & (pulseCount[7:0] == `CCPT_LOW_MAX);
    else
      cntTick = timerEnable & accumInc & (pulseCount == `CCPT_CNT_MAX);
  end

  wire [7:0] match;
  wire [7:0] capHit;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : chan
      // RQ10 - compare match
      assign match[g] = cntUpd & channelDirection[g] &
        (freeRunningCounter == channelValue[g]);
      // RQ8 - capture edge
      assign capHit[g] = ~channelDirection[g] &
        ((capEdgeCfg[2*g] & rise[g]) | (capEdgeCfg[2*g+1] & fall[g]));
    end
  endgenerate

  // RQ12 - channel 7 fires
  wire ch7Fire = match[7] | wrForce[7];
  // RQ14 - top value one cycle
  wire topReset = counterResetEnable & match[7] &
    (channelValue[7] != `CCPT_RST16);

  // ----------------------------------------
  // Synchroniser and prescaler
  // ----------------------------------------
  // RQ6 - synchronised pins
  // RQ24 - two flip-flop sync
  always @(posedge clk)
  begin
    if (reset)
    begin
      sync1 <= `CCPT_RST8;
      sync2 <= `CCPT_RST8;
      sync3 <= `CCPT_RST8;
      presCnt <= 7'h00;
    end
    else
    begin
      sync1 <= chanPinIn;
      sync2 <= sync1;
      sync3 <= sync2;
      presCnt <= timerEnable ? presCnt + 7'h01 : 7'h00;
    end
  end

  // ----------------------------------------
  // Free-running counter and channel values
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      freeRunningCounter <= `CCPT_RST16;
      cntUpd <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
        channelValue[k] <= `CCPT_RST16;
    end
    else
    begin
      cntUpd <= 1'b0;
      // RQ13 - channel 7 reset
      if (topReset)
      begin
        freeRunningCounter <= `CCPT_RST16;
        cntUpd <= 1'b1;
      end
      else if (cntTick)
      begin
        freeRunningCounter <= freeRunningCounter + 16'h0001;
        cntUpd <= 1'b1;
      end
      for (k = 0; k < 8; k = k + 1)
      begin
        // RQ8 - capture counter
        if (capHit[k])
          channelValue[k] <= freeRunningCounter;
        else if (wrStrobe && wrIdx == `CCPT_IDX_VAL0 + k[7:0] &&
          channelDirection[k])
          channelValue[k] <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Flags and pulse counter
  // ----------------------------------------
  wire [7:0] chanClr = (wrStrobe && wrIdx == `CCPT_IDX_FLAG1 &&
    timerEnable) ? hwdata[7:0] : `CCPT_RST8;
  wire tofClr = wrStrobe & (wrIdx == `CCPT_IDX_FLAG2) & timerEnable &
    hwdata[`CCPT_F2_TOF];
  // RQ3 - W1C with timer on
  wire [1:0] accClr = (wrStrobe && wrIdx == `CCPT_IDX_AFLG &&
    timerEnable) ? hwdata[1:0] : 2'b00;
  // RQ1 - fast clear on access
  wire accFast = acntAccess & fastFlagClear & timerEnable;
  // RQ2 - rollover detect
  wire accOvf = accumInc & (pulseCount == `CCPT_CNT_MAX);

  always @(posedge clk)
  begin
    if (reset)
    begin
      channelFlag <= `CCPT_RST8;
      counterOverflowFlag <= 1'b0;
      accumOverflowFlag <= 1'b0;
      accumInputFlag <= 1'b0;
      pulseCount <= `CCPT_RST16;
    end
    else
    begin
      // RQ9 - set wins over clear
      channelFlag <= (channelFlag & ~chanClr) | match | capHit;
      counterOverflowFlag <= (counterOverflowFlag & ~tofClr) |
        (cntTick & ~topReset & (freeRunningCounter == `CCPT_CNT_MAX));
      accumOverflowFlag <= (accumOverflowFlag & ~accClr[`CCPT_AF_OVF] &
        ~accFast) | accOvf;
      // RQ4 - input flag edge
      accumInputFlag <= (accumInputFlag & ~accClr[`CCPT_AF_INF] &
        ~accFast) | (accumEnable & accEdge);
      // RQ5 - word write of count
      if (wrStrobe && wrIdx == `CCPT_IDX_ACNTH)
        pulseCount <= hwdata[15:0];
      else if (wrStrobe && wrIdx == `CCPT_IDX_ACNTL)
        pulseCount <= {pulseCount[15:8], hwdata[7:0]};
      else if (accumInc)
        pulseCount <= pulseCount + 16'h0001;
    end
  end

  // ----------------------------------------
  // Compare outputs and pins
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      ocState <= `CCPT_RST8;
      chanPinOut <= `CCPT_RST8;
      chanPinOe <= `CCPT_RST8;
    end
    else
    begin
      // Own loop index, so no two processes drive one variable
      for (j = 0; j < 8; j = j + 1)
      begin
        // RQ12 - masked data wins
        if (ch7Fire && channel7Mask[j])
          ocState[j] <= channel7Data[j];
        // RQ11 - forced action
        else if (match[j] || wrForce[j])
          ocState[j] <= ocAct(modeLevel[2*j+1 -: 2], ocState[j]);
        // RQ15 - owned pin ignores latch
        if (modeLevel[2*j+1 -: 2] != 2'b00 || channel7Mask[j])
          chanPinOut[j] <= ocState[j];
        else
          chanPinOut[j] <= portLatch[j];
      end
      chanPinOe <= channelDirection;
    end
  end

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  // RQ21 - eleven request lines
  always @(posedge clk)
  begin
    if (reset)
    begin
      chanIrq <= `CCPT_RST8;
      accumInputIrq <= 1'b0;
      accumOverflowIrq <= 1'b0;
      counterOverflowIrq <= 1'b0;
    end
    else
    begin
      // RQ9 - enable gates flag
      chanIrq <= channelFlag & channelIrqEnable;
      accumInputIrq <= accumInputFlag & accumCtrl[`CCPT_AC_INI];
      // RQ17 - overflow irq enable
      accumOverflowIrq <= accumOverflowFlag & accumCtrl[`CCPT_AC_OVI];
      counterOverflowIrq <= counterOverflowFlag & counterOverflowIrqEnable;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      channelDirection <= `CCPT_RST8;
      channel7Mask <= `CCPT_RST8;
      channel7Data <= `CCPT_RST8;
      modeLevel <= `CCPT_RST16;
      capEdgeCfg <= `CCPT_RST16;
      channelIrqEnable <= `CCPT_RST8;
      portLatch <= `CCPT_RST8;
      timerEnable <= 1'b0;
      fastFlagClear <= 1'b0;
      counterOverflowIrqEnable <= 1'b0;
      counterResetEnable <= 1'b0;
      prescaleSelect <= 3'h0;
      accumCtrl <= `CCPT_RST8;
    end
    else if (wrStrobe)
    begin
      if (wrIdx == `CCPT_IDX_DIR)
        channelDirection <= hwdata[7:0];
      else if (wrIdx == `CCPT_IDX_MASK7)
        channel7Mask <= hwdata[7:0];
      else if (wrIdx == `CCPT_IDX_DATA7)
        channel7Data <= hwdata[7:0];
      else if (wrIdx == `CCPT_IDX_MODE)
        modeLevel <= hwdata[15:0];
      else if (wrIdx == `CCPT_IDX_EDGE)
        capEdgeCfg <= hwdata[15:0];
      else if (wrIdx == `CCPT_IDX_IEN)
        channelIrqEnable <= hwdata[7:0];
      else if (wrIdx == `CCPT_IDX_PORT)
        portLatch <= hwdata[7:0];
      else if (wrIdx == `CCPT_IDX_CTRL1)
      begin
        timerEnable <= hwdata[`CCPT_C1_TEN];
        fastFlagClear <= hwdata[`CCPT_C1_FFCA];
      end
      else if (wrIdx == `CCPT_IDX_CTRL2)
      begin
        counterOverflowIrqEnable <= hwdata[`CCPT_C2_TOI];
        counterResetEnable <= hwdata[`CCPT_C2_CRE];
        prescaleSelect <= hwdata[2:0];
      end
      else if (wrIdx == `CCPT_IDX_ACTL)
        accumCtrl <= {1'b0, hwdata[6:0]};
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    rdMux = 32'h00000000;
    if (aIdx == `CCPT_IDX_DIR)
      rdMux[7:0] = channelDirection;
    else if (aIdx == `CCPT_IDX_MASK7)
      rdMux[7:0] = channel7Mask;
    else if (aIdx == `CCPT_IDX_DATA7)
      rdMux[7:0] = channel7Data;
    else if (aIdx == `CCPT_IDX_COUNT)
      rdMux[15:0] = freeRunningCounter;
    else if (aIdx == `CCPT_IDX_CTRL1)
      rdMux[7:0] = {timerEnable, 2'b00, fastFlagClear, 4'h0};
    else if (aIdx == `CCPT_IDX_MODE)
      rdMux[15:0] = modeLevel;
    else if (aIdx == `CCPT_IDX_EDGE)
      rdMux[15:0] = capEdgeCfg;
    else if (aIdx == `CCPT_IDX_IEN)
      rdMux[7:0] = channelIrqEnable;
    else if (aIdx == `CCPT_IDX_CTRL2)
      rdMux[7:0] = {counterOverflowIrqEnable, 3'h0, counterResetEnable,
        prescaleSelect};
    else if (aIdx == `CCPT_IDX_FLAG1)
      rdMux[7:0] = channelFlag;
    else if (aIdx == `CCPT_IDX_FLAG2)
      rdMux[7:0] = {counterOverflowFlag, 7'h00};
    else if (aIdx >= `CCPT_IDX_VAL0 && aIdx < `CCPT_IDX_VAL0 + 8'h08)
      rdMux[15:0] = channelValue[aIdx[2:0]];
    else if (aIdx == `CCPT_IDX_ACTL)
      rdMux[7:0] = accumCtrl;
    else if (aIdx == `CCPT_IDX_AFLG)
      rdMux[7:0] = {6'h00, accumOverflowFlag, accumInputFlag};
    else if (aIdx == `CCPT_IDX_ACNTH)
      rdMux[15:0] = pulseCount;
    else if (aIdx == `CCPT_IDX_ACNTL)
      rdMux[7:0] = pulseCount[7:0];
    else if (aIdx == `CCPT_IDX_PORT)
      rdMux[7:0] = portLatch;
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero wait states: read data is sampled in the address phase
  always @(posedge clk)
  begin
    if (reset)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= 1'b0;
      wrIdx <= `CCPT_RST8;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= busTake & hwrite;
      wrIdx <= aIdx;
      if (busTake && !hwrite)
        hrdata <= rdMux;
    end
  end

endmodule
`default_nettype wire

// file: tb/ccpt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------
// Channel pin driver
// ------------------
module ccpt_pin_model
(
  // Clock
  input wire logic clk,
  // Pin levels
  output var logic [7:0] pinLevel
);
  initial pinLevel = 8'h00;
  // wide levels
  // Each level lasts three clocks or more, shorter ones may be lost
  task automatic pulse(input logic [7:0] pins, input int width);
    @(posedge clk);
    pinLevel <= pinLevel ^ pins;
    repeat (width) @(posedge clk);
    pinLevel <= pinLevel ^ pins;
    repeat (width) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/ccpt_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccpt_map.vh"
// ------------
// Port checker
// ------------
module ccpt_timer_sva
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Pins and requests
  input wire [7:0] chanPinOe,
  input wire [7:0] chanIrq,
  input wire accumInputIrq,
  input wire accumOverflowIrq,
  input wire counterOverflowIrq
);
  wire taken = hsel && hready && htrans[1];
  wire rdTaken = taken && !hwrite;
  wire [7:0] idx = haddr[9:2];
  wire [10:0] irqs = {chanIrq, accumInputIrq, accumOverflowIrq, counterOverflowIrq};
  // Requests only fall after software touched the bus
  reg [2:0] quietCnt;
  reg [2:0] dirWr;
  always @(posedge clk)
  begin
    if (reset)
    begin
      quietCnt <= 3'h7;
      dirWr <= 3'h0;
    end
    else
    begin
      quietCnt <= taken ? 3'h0 : quietCnt + {2'h0, quietCnt != 3'h7};
      dirWr <= {dirWr[1:0], taken && hwrite && idx == `CCPT_IDX_DIR};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence readAt(lo, hi);
    rdTaken && idx >= lo && idx <= hi;
  endsequence
  a_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("slave stalled");
  a_reset_quiet: assert property ($fell(reset) |-> irqs == 0 && chanPinOe == 0)
    else $error("active after reset");
  a_force_reads_zero: assert property ((readAt(8'h01, 8'h01) or readAt(8'h31, 8'hff))
    |=> hrdata == 0) else $error("nonzero read");
  a_flag_width: assert property (readAt(`CCPT_IDX_AFLG, `CCPT_IDX_AFLG)
    |=> hrdata[31:2] == 0) else $error("flag bits wide");
  a_count_word: assert property (readAt(`CCPT_IDX_ACNTH, `CCPT_IDX_ACNTH)
    |=> hrdata[31:16] == 0) else $error("count wide");
  a_rdata_holds: assert property (!rdTaken |=> hrdata == $past(hrdata))
    else $error("read data moved");
  a_irq_by_bus: assert property (|($past(irqs) & ~irqs) |-> quietCnt <= 3'h4)
    else $error("request fell alone");
  a_oe_dir_write: assert property (chanPinOe != $past(chanPinOe) |-> |dirWr)
    else $error("enable moved alone");
endmodule
bind ccpt_timer ccpt_timer_sva u_ccpt_timer_sva
(
  .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .chanPinOe, .chanIrq, .accumInputIrq, .accumOverflowIrq, .counterOverflowIrq
);
`default_nettype wire

// file: tb/ccpt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccpt_map.vh"
module ccpt_timer_tb;
  // -------
  // Signals
  // -------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, accumInputIrq, accumOverflowIrq, counterOverflowIrq;
  wire [7:0] chanPinIn, chanPinOut, chanPinOe, chanIrq;
  int miscompares = 0;
  int nCompared = 0;
  int g;
  logic p;
  logic [31:0] rd;
  typedef struct packed {logic [7:0] idx; logic [15:0] wd, pre, exp;} ccpt_row_t;
  ccpt_row_t rows [12] = '{
    '{8'h00, 16'h00a5, 16'h0, 16'h00a5}, '{8'h01, 16'h00ff, 16'h0, 16'h0},
    '{8'h02, 16'h003c, 16'h0, 16'h003c}, '{8'h03, 16'h005a, 16'h0, 16'h005a},
    '{8'h08, 16'h1234, 16'h0, 16'h1234}, '{8'h0a, 16'h4321, 16'h0, 16'h4321},
    '{8'h0d, 16'h0007, 16'h0, 16'h0007}, '{8'h10, 16'hbeef, 16'h0, 16'hbeef},
    '{8'h22, 16'h1234, 16'h0, 16'h1234}, '{8'h23, 16'h0056, 16'h0034, 16'h0056},
    '{8'h30, 16'h005a, 16'h0, 16'h005a}, '{8'h3f, 16'hffff, 16'h0, 16'h0}};
  always #25 clk = ~clk;
  ccpt_timer u_ccpt_timer
  (
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chanPinIn, .chanPinOut,
    .chanPinOe, .chanIrq, .accumInputIrq, .accumOverflowIrq, .counterOverflowIrq
  );
  ccpt_pin_model u_ccpt_pin_model (.clk, .pinLevel(chanPinIn));
  // -----
  // Tasks
  // -----
  task automatic finalReport;
    if (miscompares == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bail;
    miscompares++;
    finalReport;
  endtask
  task automatic waitReady;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
      bail;
  endtask
  // whole word
  // One word per access, though the count's low byte at CCPT_IDX_ACNTL is also written and read alone
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    waitReady;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  task automatic doReset;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask
  task automatic pinGap(output int gap);
    logic last;
    last = chanPinOut[1];
    gap = 0;
    while (chanPinOut[1] === last && gap < 99)
    begin
      @(posedge clk);
      gap++;
    end
    if (gap >= 99)
      bail;
  endtask
  // ---------
  // Sequence
  // ---------
  initial
  begin
    doReset;
    foreach (rows[i])
    begin
      rdChk(rows[i].idx, rows[i].pre);
      wr(rows[i].idx, rows[i].wd);
      rdChk(rows[i].idx, rows[i].exp);
    end
    doReset;
    chk({chanIrq, accumInputIrq, accumOverflowIrq, counterOverflowIrq, chanPinOe}, 0);
    // Event counting with the timer off
    wr(`CCPT_IDX_ACTL, 32'h53);
    wr(`CCPT_IDX_ACNTH, 32'hfffe);
    repeat (2) u_ccpt_pin_model.pulse(8'h80, 3);
    rdChk(`CCPT_IDX_ACNTH, 32'h0);
    rdChk(`CCPT_IDX_AFLG, 32'h3);
    chk({accumInputIrq, accumOverflowIrq}, 2'h3);
    wr(`CCPT_IDX_ACTL, 32'h50);
    repeat (2) @(posedge clk);
    chk({accumInputIrq, accumOverflowIrq}, 2'h0);
    wr(`CCPT_IDX_AFLG, 32'h3);
    rdChk(`CCPT_IDX_AFLG, 32'h3);
    wr(`CCPT_IDX_CTRL1, 32'h80);
    wr(`CCPT_IDX_AFLG, 32'h1);
    rdChk(`CCPT_IDX_AFLG, 32'h2);
    wr(`CCPT_IDX_CTRL1, 32'h90);
    rdChk(`CCPT_IDX_ACNTL, 32'h0);
    rdChk(`CCPT_IDX_AFLG, 32'h0);
    // Gated mode, first without the divided clock
    wr(`CCPT_IDX_CTRL1, 32'h0);
    wr(`CCPT_IDX_ACTL, 32'h60);
    u_ccpt_pin_model.pulse(8'h80, 200);
    rdChk(`CCPT_IDX_ACNTH, 32'h0);
    rdChk(`CCPT_IDX_AFLG, 32'h1);
    wr(`CCPT_IDX_CTRL1, 32'h80);
    u_ccpt_pin_model.pulse(8'h80, 640);
    bus(1'b0, `CCPT_IDX_ACNTH, 32'h0);
    chk(rd >= 9 && rd <= 11, 1);
    // Channel one toggles, channel seven wraps the counter at 7
    doReset;
    wr(`CCPT_IDX_DIR, 32'h82);
    wr(`CCPT_IDX_MODE, 32'h4);
    wr(`CCPT_IDX_VAL0 + 8'h1, 32'h3);
    wr(`CCPT_IDX_VAL0 + 8'h7, 32'h7);
    wr(`CCPT_IDX_CTRL2, 32'h8);
    wr(`CCPT_IDX_CTRL1, 32'h80);
    chk(chanPinOe, 8'h82);
    repeat (2) pinGap(g);
    chk(g, 8);
    wr(`CCPT_IDX_PORT, 32'h82);
    repeat (2) pinGap(g);
    chk(g, 8);
    chk(chanPinOut[7], 1'b1);
    wr(`CCPT_IDX_MASK7, 32'h2);
    repeat (3) pinGap(g);
    chk(g, 4);
    // Forced action, channel one moved out of the counter's reach
    // Its flag is cleared first so a wrongly set flag shows up
    wr(`CCPT_IDX_MASK7, 32'h0);
    wr(`CCPT_IDX_VAL0 + 8'h1, 32'h100);
    wr(`CCPT_IDX_FLAG1, 32'h2);
    repeat (2) @(posedge clk);
    p = chanPinOut[1];
    wr(`CCPT_IDX_FORCE, 32'h2);
    repeat (2) @(posedge clk);
    chk(chanPinOut[1], {31'h0, ~p});
    bus(1'b0, `CCPT_IDX_FLAG1, 32'h0);
    chk(rd[1], 1'b0);
    // Capture on a rising edge of channel zero
    wr(`CCPT_IDX_CTRL1, 32'h80);
    wr(`CCPT_IDX_DIR, 32'h0);
    wr(`CCPT_IDX_FLAG1, 32'hff);
    wr(`CCPT_IDX_EDGE, 32'h1);
    wr(`CCPT_IDX_IEN, 32'h1);
    u_ccpt_pin_model.pulse(8'h01, 3);
    chk(chanIrq, 8'h01);
    wr(`CCPT_IDX_FLAG1, 32'h1);
    repeat (2) @(posedge clk);
    chk(chanIrq, 8'h0);
    finalReport;
  end
endmodule
`default_nettype wire
